// ### tb/handler_model.sv
`timescale 1ns/10ps
`default_nettype none
module handler_model (
  input wire logic sys_clk_i,
  output logic external_trigger_o
);
  initial external_trigger_o = 1'b0;
  // Released low after each pulse so the device can rearm.
  task automatic fire(input int hi_cyc);
    @(negedge sys_clk_i);
    external_trigger_o = 1'b1;
    repeat (hi_cyc) @(negedge sys_clk_i);
    external_trigger_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### tb/list_sweep_judge_properties.sv
`timescale 1ns/10ps
`default_nettype none
module list_sweep_judge_chk
  import list_sweep_pkg::*;
#(
  parameter int NUM_POINTS = 10,
  parameter int TRIG_MIN_CYC = 250
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic external_trigger_mode_i,
  input wire logic int_trigger_i,
  input wire logic analog_done_i,
  input wire logic meas_start_o,
  input wire logic busy_o,
  input wire judgement_t judgement_o,
  input wire logic analog_done_strobe_n_o,
  input wire logic measurement_end_strobe_n_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  start_pulse_a: assert property (meas_start_o |=> !meas_start_o)
    else $error("start pulse too long");
  int_start_a: assert property (!busy_o && !external_trigger_mode_i && int_trigger_i |=> meas_start_o)
    else $error("trigger did not start");
  busy_start_a: assert property (meas_start_o |-> busy_o)
    else $error("start while idle");
  end_width_a: assert property ($fell(measurement_end_strobe_n_o) |->
    !measurement_end_strobe_n_o [*8] ##1 measurement_end_strobe_n_o)
    else $error("end strobe width");
  analog_width_a: assert property ($fell(analog_done_strobe_n_o) |->
    !analog_done_strobe_n_o [*8] ##1 analog_done_strobe_n_o)
    else $error("analog strobe width");
  analog_cause_a: assert property ($fell(analog_done_strobe_n_o) |-> $past(analog_done_i))
    else $error("analog strobe without cause");
  judge_hold_a: assert property ($changed(judgement_o) |=> $fell(measurement_end_strobe_n_o))
    else $error("judgement changed without end strobe");
  verdict_any_a: assert property (judgement_o.overall_verdict_n ==
    &judgement_o.point_fail_flags_n)
    else $error("verdict not any-fail");
  aux_any_a: assert property (judgement_o.aux_fail_n == judgement_o.overall_verdict_n)
    else $error("aux differs from verdict");
  cover property ($fell(measurement_end_strobe_n_o) && !judgement_o.overall_verdict_n);
  cover property ($fell(analog_done_strobe_n_o));
  cover property (meas_start_o && external_trigger_mode_i);
endmodule
bind list_sweep_judge list_sweep_judge_chk #(
  .NUM_POINTS(NUM_POINTS),
  .TRIG_MIN_CYC(TRIG_MIN_CYC)
) chk_u (
  .sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i),
  .external_trigger_mode_i(external_trigger_mode_i),
  .int_trigger_i(int_trigger_i),
  .analog_done_i(analog_done_i),
  .meas_start_o(meas_start_o),
  .busy_o(busy_o),
  .judgement_o(judgement_o),
  .analog_done_strobe_n_o(analog_done_strobe_n_o),
  .measurement_end_strobe_n_o(measurement_end_strobe_n_o)
);
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin failures++; \
  $display("mismatch %s exp %h got %h", nm, e, a); end end
module tb;
  import list_sweep_pkg::*;
  localparam int TMIN = 2;
  logic sys_clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic sequential = 1'h0;
  logic ext = 1'h0;
  logic itrig = 1'h0;
  logic adone = 1'h0;
  logic external_trigger;
  logic [3:0] cnt = 4'h0;
  logic [3:0] idx;
  logic [9:0] pat = 10'h0;
  point_result_t res = '0;
  judgement_t jud;
  logic mstart, astb_n, estb_n, busy;
  logic astb_q = 1'h1;
  logic [31:0] s = 32'h5a;
  int failures = 0, total_checks = 0, cyc = 0, acnt = 0;
  always #2 sys_clk_i = ~sys_clk_i;
  handler_model hnd_u (.sys_clk_i(sys_clk_i), .external_trigger_o(external_trigger));
  list_sweep_judge #(.TRIG_MIN_CYC(TMIN)) dut_u (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sequential_sweep_i(sequential),
    .external_trigger_mode_i(ext), .point_count_i(cnt), .external_trigger_i(external_trigger),
    .int_trigger_i(itrig), .meas_start_o(mstart), .meas_index_o(idx),
    .analog_done_i(adone), .result_i(res), .judgement_o(jud),
    .analog_done_strobe_n_o(astb_n), .measurement_end_strobe_n_o(estb_n), .busy_o(busy));
  function logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic judgement_t expj(logic [9:0] p, int n);
    logic [9:0] m;
    m = p & ((10'h1 << n) - 10'h1);
    return '{~m, ~|m, ~|m};
  endfunction
  // Measurement engine: answers each start with a random analog delay.
  always begin
    logic [3:0] k;
    @(negedge sys_clk_i);
    if (mstart) begin
      k = idx;
      repeat (rnd() % 3 + 1) @(negedge sys_clk_i);
      adone = 1'h1;
      @(negedge sys_clk_i);
      adone = 1'h0;
      repeat (2) @(negedge sys_clk_i);
      res = '{1'h1, k, pat[k]};
      @(negedge sys_clk_i);
      res = '0;
    end
  end
  always @(negedge sys_clk_i) begin
    if (!astb_n && astb_q) acnt++;
    astb_q = astb_n;
  end
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      print_verdict();
    end
  end
  task print_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic run(bit sq, bit ex, logic [3:0] c, logic [9:0] p);
    int n;
    n = (c == 0 || c > 10) ? 10 : int'(c);
    sequential = sq;
    ext = ex;
    cnt = c;
    pat = p;
    acnt = 0;
    for (int i = 1; i <= (sq ? 1 : n); i++) begin
      if (ex) hnd_u.fire(TMIN + 1);
      else begin
        itrig = 1'h1;
        @(negedge sys_clk_i);
        itrig = 1'h0;
      end
      while (estb_n) @(negedge sys_clk_i);
      `CHK("judgement", expj(p, sq ? n : i), jud)
      `CHK("analog strobes", sq ? 1 : i, acnt)
      `CHK("index", 4'(sq ? 0 : i % n), idx)
      while (!estb_n || busy) @(negedge sys_clk_i);
    end
  endtask
  initial begin
    repeat (3) @(negedge sys_clk_i);
    rst_n_i = 1'h1;
    run(1, 0, 4'ha, 10'h000);
    run(1, 1, 4'h0, 10'h3ff);
    run(1, 0, 4'h1, 10'h001);
    run(0, 1, 4'h3, 10'h005);
    run(0, 0, 4'hf, 10'h200);
    repeat (6) run(1'(rnd()), 1'(rnd()), 4'(rnd()), 10'(rnd()));
    print_verdict();
  end
endmodule
`default_nettype wire

// ### verilog/list_sweep_judge.sv
`timescale 1ns/10ps
`default_nettype none
`include "list_sweep_map.svh"


module list_sweep_judge
  import list_sweep_pkg::*;
#(
  parameter int NUM_POINTS = `LS_NUM_POINTS,
  parameter int TRIG_MIN_CYC = `LS_TRIG_MIN_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Configuration
  input wire logic sequential_sweep_i,
  input wire logic external_trigger_mode_i,
  input wire logic [3:0] point_count_i,
  // Triggers
  input wire logic external_trigger_i,
  input wire logic int_trigger_i,
  // Measurement engine
  output logic meas_start_o,
  output logic [3:0] meas_index_o,
  input wire logic analog_done_i,
  input wire point_result_t result_i,
  // Handler outputs
  output judgement_t judgement_o,
  output logic analog_done_strobe_n_o,
  output logic measurement_end_strobe_n_o,
  // Status
  output logic busy_o
);

  // ---------------------------------------------------------------
  // Trigger qualification
  // ---------------------------------------------------------------

  logic trig_prev;
  logic [15:0] trig_high_cnt;
  logic trig_armed;
  logic start_req;

  // A rising edge is taken only after the line has been high long enough;
  // this filters glitches shorter than the least pulse width.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      trig_prev <= 1'b0;
      trig_high_cnt <= 16'h0000;
      trig_armed <= 1'b0;
    end else begin
      trig_prev <= external_trigger_i;
      if (!external_trigger_i) begin
        trig_high_cnt <= 16'h0000;
        trig_armed <= 1'b1;
      end else if (trig_high_cnt != 16'hffff) begin
        trig_high_cnt <= trig_high_cnt + 16'h0001;
      end
      // Only an external start uses up the armed edge; an internal start
      // must not make the handler raise its line twice.
      if (start_req && external_trigger_mode_i) begin
        trig_armed <= 1'b0;
      end
    end
  end

  always_comb begin
    if (external_trigger_mode_i) begin
      start_req = trig_armed && external_trigger_i && trig_prev &&
                  (trig_high_cnt >= 16'(TRIG_MIN_CYC - 1));
    end else begin
      start_req = int_trigger_i;
    end
  end

  // ---------------------------------------------------------------
  // Sweep sequencer
  // ---------------------------------------------------------------

  sweep_state_t state;
  logic [3:0] index;
  logic [3:0] last_index;
  logic [NUM_POINTS-1:0] fail_acc;
  logic sequential_mode;
  logic point_done;
  logic analog_fire;
  logic end_fire;

  assign last_index = (point_count_i == 4'h0 || point_count_i > 4'(NUM_POINTS)) ?
                      4'(NUM_POINTS - 1) : point_count_i - 4'h1;
  assign point_done = (state == ST_COMPARE) && result_i.valid;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      index <= 4'h0;
      sequential_mode <= 1'b1;
      meas_start_o <= 1'b0;
    end else begin
      meas_start_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start_req) begin
            sequential_mode <= sequential_sweep_i;
            meas_start_o <= 1'b1;
            state <= ST_MEASURE;
          end
        end
        ST_MEASURE: begin
          if (analog_done_i) begin
            state <= ST_COMPARE;
          end
        end
        ST_COMPARE: begin
          if (result_i.valid) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (index == last_index) begin
            index <= 4'h0;
            state <= ST_IDLE;
          end else begin
            index <= index + 4'h1;
            if (sequential_mode) begin
              meas_start_o <= 1'b1;
              state <= ST_MEASURE;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Per-point fail bits
  // ---------------------------------------------------------------

  logic list_start;

  // A trigger taken at point zero opens a new list, so no verdict from
  // the previous part can leak into the flags of this one.
  assign list_start = (state == ST_IDLE) && start_req && (index == 4'h0);

  // Each point owns one accumulator bit, cleared when a list opens and otherwise written only by its own result.
  for (genvar p = 0; p < NUM_POINTS; p++) begin : g_point
    logic acc;

    always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
        acc <= 1'b0;
      end else if (list_start) begin
        acc <= 1'b0;
      end else if (point_done && (index == 4'(p))) begin
        acc <= result_i.out_of_limit;
      end
    end

    assign fail_acc[p] = acc;
  end

  // ---------------------------------------------------------------
  // Judgement outputs
  // ---------------------------------------------------------------

  logic list_complete;
  logic [NUM_POINTS-1:0] next_fail;

  assign list_complete = (state == ST_DONE) && (index == last_index);

  always_comb begin
    next_fail = fail_acc;
  end

  // Flags are loaded only when the list (or the step, in stepped mode)
  // has completed, so the handler never sees a half-built set.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      judgement_o <= '1;
    end else if (state == ST_DONE && (sequential_mode ? list_complete : 1'b1)) begin
      for (int i = 0; i < NUM_POINTS; i++) begin
        judgement_o.point_fail_flags_n[i] <= !next_fail[i];
      end
      judgement_o.aux_fail_n <= !(|next_fail);
      judgement_o.overall_verdict_n <= !(|next_fail);
    end
  end

  // ---------------------------------------------------------------
  // Handshake strobes
  // ---------------------------------------------------------------

  // Analog-done fires on every point in stepped mode, on the last in sequential.
  assign analog_fire = (state == ST_MEASURE) && analog_done_i &&
                       (!sequential_mode || index == last_index);
  // Measurement-end fires one cycle after the outputs load, so data leads it.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      end_fire <= 1'b0;
    end else begin
      end_fire <= (state == ST_DONE) && (!sequential_mode || list_complete);
    end
  end

  list_sweep_strobe #(
    .WIDTH(`LS_STROBE_CYC)
  ) u_analog_strobe (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .fire_i(analog_fire),
    .strobe_n_o(analog_done_strobe_n_o)
  );

  list_sweep_strobe #(
    .WIDTH(`LS_STROBE_CYC)
  ) u_end_strobe (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .fire_i(end_fire),
    .strobe_n_o(measurement_end_strobe_n_o)
  );

  assign meas_index_o = index;
  assign busy_o = (state != ST_IDLE);

endmodule

`default_nettype wire

// ### verilog/list_sweep_map.svh
`ifndef LIST_SWEEP_MAP_SVH
`define LIST_SWEEP_MAP_SVH

// Number of sweep points reported on the handler port.
`define LS_NUM_POINTS 10
// Least external trigger pulse width, in nanoseconds.
`define LS_TRIG_MIN_NS 1000
`define LS_CLK_PERIOD_NS 4
// Cycles the trigger must stay high before it counts (rounded up).
`define LS_TRIG_MIN_CYC ((`LS_TRIG_MIN_NS + `LS_CLK_PERIOD_NS - 1) / `LS_CLK_PERIOD_NS)
// Cycles each handshake strobe is held low.
`define LS_STROBE_CYC 8
// Idle level of every active-low output.
`define LS_RELEASED 1'b1

`endif

// ### verilog/list_sweep_pkg.sv
`default_nettype none
package list_sweep_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_MEASURE = 3'b001,
    ST_COMPARE = 3'b010,
    ST_DONE = 3'b011
  } sweep_state_t;

  // Measurement engine result for one point.
  typedef struct packed {
    logic valid;
    logic [3:0] index;
    logic out_of_limit;
  } point_result_t;

  // Judgement lines toward the handler, all active low.
  typedef struct packed {
    logic [9:0] point_fail_flags_n;
    logic aux_fail_n;
    logic overall_verdict_n;
  } judgement_t;

endpackage

`default_nettype wire

// ### verilog/list_sweep_strobe.sv
`timescale 1ns/10ps
`default_nettype none
`include "list_sweep_map.svh"

// Stretches a one-cycle event into an active-low pulse of fixed width.
module list_sweep_strobe
  import list_sweep_pkg::*;
#(
  parameter int WIDTH = `LS_STROBE_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Event in, strobe out
  input wire logic fire_i,
  output logic strobe_n_o
);

  logic [7:0] count;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      count <= 8'h00;
    end else if (fire_i) begin
      count <= 8'(WIDTH);
    end else if (count != 8'h00) begin
      count <= count - 8'h01;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      strobe_n_o <= `LS_RELEASED;
    end else begin
      strobe_n_o <= !(fire_i || count > 8'h01);
    end
  end

endmodule

`default_nettype wire
